// ### hw/capture_compare_pkg.sv
// constants shared by the capture/compare/pwm control block
package capture_compare_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_MODE_CONTROL  = 8'h00; // unit_mode_control
    localparam logic [7:0] OFS_VALUE_LOW     = 8'h04; // capture_value_low
    localparam logic [7:0] OFS_VALUE_HIGH    = 8'h08; // capture_value_high
    localparam logic [7:0] OFS_EVENT_STATUS  = 8'h0C; // event_flag

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int         MODE_LSB          = 0;     // mode_select_field
    localparam int         DUTY_LSB          = 4;     // duty_low_bits
    localparam int         CONFIG_BIT        = 7;     // output_config_bit
    localparam int         FLAG_BIT          = 0;     // event flag position
    localparam logic [7:0] MODE_CONTROL_MASK = 8'hBF; // bit 6 unimplemented
    localparam logic [7:0] MODE_CONTROL_RST  = 8'h00;
    localparam logic [7:0] VALUE_RST         = 8'h00;

    // ****************************************
    // mode codes and groups
    // ****************************************
    localparam logic [3:0] MODE_OFF          = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE   = 4'h2;
    localparam logic [3:0] MODE_CMP_SET      = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR    = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT     = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL  = 4'hB;
    localparam logic [1:0] GROUP_CAPTURE     = 2'h1;
    localparam logic [1:0] GROUP_PWM         = 2'h3;
    localparam logic [1:0] CAP_FALL          = 2'h0;
    localparam logic [1:0] CAP_RISE          = 2'h1;
    localparam logic [1:0] CAP_RISE_4        = 2'h2;
    localparam logic [3:0] PRESCALE_LAST_4   = 4'h3;  // 4th rising edge
    localparam logic [3:0] PRESCALE_LAST_16  = 4'hF;  // 16th rising edge

endpackage

// ### hw/capture_event_detect.sv
// pin synchroniser, edge detector and capture prescaler
`timescale 1ns/1ps

module capture_event_detect
    import capture_compare_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       event_pin_in,      // pad level, asynchronous
    input  wire logic [3:0] mode_select_field,
    output logic            capture_pulse      // one cycle per capture
);

    // ****************************************
    // synchroniser and edge history
    // ****************************************
    logic       sync_meta;   // first stage, read only by sync_level
    logic       sync_level;  // second stage
    logic       level_prev;  // history for edge detection
    logic [3:0] edge_count;  // rising edge prescaler

    wire        rise_seen  = sync_level & ~level_prev; // (R21)
    wire        fall_seen  = ~sync_level & level_prev; // (R21)
    wire        in_capture = mode_select_field[3:2] == GROUP_CAPTURE;
    wire [1:0]  sub_mode   = mode_select_field[1:0];
    wire [3:0]  last_count = (sub_mode == CAP_RISE_4) ? PRESCALE_LAST_4
                                                      : PRESCALE_LAST_16;
    wire        at_last    = edge_count == last_count;
    // edge choice per capture sub mode
    wire        hit        = (sub_mode == CAP_FALL)   ? fall_seen :
                             (sub_mode == CAP_RISE)   ? rise_seen :
                             (rise_seen & at_last);           // (R3)
    wire [3:0]  next_count = at_last ? 4'h0 : edge_count + 4'h1;

    // two flops before any logic looks at the pin; a port write that
    // flips a driven pin reaches here like any outside edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta  <= 1'b0;
            sync_level <= 1'b0;
            level_prev <= 1'b0;
        end else begin
            sync_meta  <= event_pin_in;           // (R17)
            sync_level <= sync_meta;              // (R21)
            level_prev <= sync_level;
        end
    end

    // prescaler: cleared outside capture, kept across sub mode changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_count <= 4'h0;                   // (R19)
        end else if (!in_capture) begin
            edge_count <= 4'h0;                   // (R19)
        end else if (rise_seen) begin
            edge_count <= next_count;
        end
    end

    // registered capture strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_pulse <= 1'b0;
        end else begin
            capture_pulse <= in_capture & hit;    // (R3)
        end
    end

endmodule

// ### hw/enhanced_capture_compare_pwm_ctrl.sv
// capture/compare/pwm control block with apb register access
`timescale 1ns/1ps

// Operation
// (R1) capture/compare use first timer, pwm second
// (R2) mode 0000 turns unit off, resets state
// (R3) capture falling, rising, 4th, 16th rising
// (R4) 0010 toggles pin on match, sets flag
// (R5) 1000 drives high, 1001 low, set flag
// (R6) 1010 sets flag only, pin untouched
// (R7) 1011 flags, resets timer, starts conversion
// (R8) 1100-1111 pwm with four polarity pairs
// (R9) software avoids reserved codes 0001, 0011
// (R10) non-pwm ignores config bit, secondary free
// (R11) pwm single or half-bridge by config bit
// (R12) duty low bits extend value to ten
// (R13) capture copies full first timer count
// (R14) flag set per capture, software clears
// (R15) new capture overwrites unread value
// (R16) software makes pin input for capture
// (R17) port write on driven pin may capture
// (R18) bit 6 reads zero, resets zero
// (R19) prescaler cleared by reset, off, non-capture
// (R20) software keeps first timer synchronous
// (R21) pin synchronised, one capture per edge
module enhanced_capture_compare_pwm_ctrl
    import capture_compare_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_pin_in,
    input  wire logic [15:0] first_timer_count,
    input  wire logic [9:0]  second_timer_count,
    input  wire logic        adc_enabled,
    output logic             primary_out,
    output logic             primary_oe_n,
    output logic             secondary_out,
    output logic             secondary_oe_n,
    output logic             timer_reset,
    output logic             adc_start,
    output logic             event_flag
);

    // ****************************************
    // registers and state
    // ****************************************
    logic [7:0] unit_mode_control;   // control register
    logic [7:0] capture_value_low;   // value low byte
    logic [7:0] capture_value_high;  // value high byte
    logic       compare_latch;       // compare output latch
    logic       match_prev;          // match history, one hit per match
    logic       capture_pulse;       // from the edge detector
    logic       pwm_primary;         // pwm levels
    logic       pwm_secondary;

    // ****************************************
    // field decode
    // ****************************************
    wire [3:0] mode_select_field = unit_mode_control[MODE_LSB +: 4];
    wire [1:0] duty_low_bits     = unit_mode_control[DUTY_LSB +: 2];
    wire       output_config_bit = unit_mode_control[CONFIG_BIT];
    wire [1:0] mode_group        = mode_select_field[3:2];
    wire       unit_off          = mode_select_field == MODE_OFF;
    wire       pwm_mode          = mode_group == GROUP_PWM;
    // compare codes: 0010 and 1000..1011
    wire       compare_mode      = mode_select_field == MODE_CMP_TOGGLE
                                 | mode_group == 2'h2;
    // pins driven by compare: toggle, set, clear only
    wire       compare_drives    = mode_select_field == MODE_CMP_TOGGLE
                                 | mode_select_field == MODE_CMP_SET
                                 | mode_select_field == MODE_CMP_CLEAR;
    wire [15:0] stored_value     = {capture_value_high, capture_value_low};

    // ****************************************
    // compare match against the first timer
    // ****************************************
    wire timer_equal  = first_timer_count == stored_value;     // (R1)
    // one event per match; a held match does not retoggle
    wire match_event  = compare_mode & timer_equal & ~match_prev;
    wire special_hit  = match_event &
                        (mode_select_field == MODE_CMP_SPECIAL);

    // ****************************************
    // apb decode
    // ****************************************
    wire setup_phase  = psel & ~penable;
    wire access_done  = psel & penable & pready;
    wire wr_done      = access_done & pwrite;
    wire hit_control  = paddr == OFS_MODE_CONTROL;
    wire hit_low      = paddr == OFS_VALUE_LOW;
    wire hit_high     = paddr == OFS_VALUE_HIGH;
    wire hit_status   = paddr == OFS_EVENT_STATUS;
    wire addr_mapped  = hit_control | hit_low | hit_high | hit_status;
    wire wr_control   = wr_done & hit_control;
    wire wr_low       = wr_done & hit_low;
    wire wr_high      = wr_done & hit_high;
    wire clear_flag   = wr_done & hit_status & pwdata[FLAG_BIT];
    wire set_flag     = capture_pulse | match_event;     // (R14)

    // read data mux, unused bits zero
    wire [7:0] read_byte =
        hit_control ? (unit_mode_control & MODE_CONTROL_MASK) :
        hit_low     ? capture_value_low  :
        hit_high    ? capture_value_high :
        hit_status  ? {7'h00, event_flag} : 8'h00;

    // ****************************************
    // next values
    // ****************************************
    wire [7:0] next_control = pwdata[7:0] & MODE_CONTROL_MASK; // (R18)
    // capture wins over a software write in the same cycle
    wire [7:0] next_low  = capture_pulse ? first_timer_count[7:0]
                                         : pwdata[7:0];
    wire [7:0] next_high = capture_pulse ? first_timer_count[15:8]
                                         : pwdata[7:0];
    // compare latch action per mode
    wire next_latch =
        (mode_select_field == MODE_CMP_TOGGLE) ? ~compare_latch :  // (R4)
        (mode_select_field == MODE_CMP_SET)    ? 1'b1 :            // (R5)
        (mode_select_field == MODE_CMP_CLEAR)  ? 1'b0 :            // (R5)
                                                 compare_latch;    // (R6)
    // pin levels and enables per mode group
    wire next_primary_out   = pwm_mode ? pwm_primary : compare_latch;
    wire next_primary_oe_n  = ~(pwm_mode | compare_drives);
    // outside pwm the secondary pin is left to the port
    wire next_second_oe_n   = ~(pwm_mode & output_config_bit); // (R10)

    // ****************************************
    // capture event source
    // ****************************************
    capture_event_detect u_capture_event_detect (
        .pclk              (pclk),
        .presetn           (presetn),
        .event_pin_in      (event_pin_in),
        .mode_select_field (mode_select_field),
        .capture_pulse     (capture_pulse)
    );

    // ****************************************
    // pwm stage on the second timer
    // ****************************************
    pwm_output_stage #(
        .DUTY_WIDTH (10)
    ) u_pwm_output_stage (
        .pclk            (pclk),
        .presetn         (presetn),
        .pwm_enable      (pwm_mode),                     // (R8)
        .half_bridge     (output_config_bit),            // (R11)
        .polarity        (mode_select_field[1:0]),
        .duty            ({capture_value_low, duty_low_bits}), // (R12)
        .timebase        (second_timer_count),           // (R1)
        .primary_level   (pwm_primary),
        .secondary_level (pwm_secondary)
    );

    // ****************************************
    // register file
    // ****************************************
    // control register, bit 6 never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_mode_control <= MODE_CONTROL_RST;       // (R18)
        end else if (wr_control) begin
            unit_mode_control <= next_control;
        end
    end

    // value pair; capture loads the whole count at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_low  <= VALUE_RST;
            capture_value_high <= VALUE_RST;
        end else begin
            if (capture_pulse | wr_low) begin
                capture_value_low  <= next_low;          // (R13) (R15)
            end
            if (capture_pulse | wr_high) begin
                capture_value_high <= next_high;         // (R13) (R15)
            end
        end
    end

    // sticky flag, a new event beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_flag <= 1'b0;
        end else if (set_flag) begin
            event_flag <= 1'b1;                          // (R14)
        end else if (clear_flag) begin
            event_flag <= 1'b0;                          // (R14)
        end
    end

    // ****************************************
    // apb answer: zero wait, ready in first access cycle
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~addr_mapped;
            prdata  <= setup_phase ? {24'h00_0000, read_byte}
                                   : 32'h0000_0000;
        end
    end

    // ****************************************
    // compare state; off clears it
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_latch <= 1'b0;
            match_prev    <= 1'b0;
        end else if (unit_off) begin
            compare_latch <= 1'b0;                       // (R2)
            match_prev    <= 1'b0;                       // (R2)
        end else begin
            match_prev    <= compare_mode & timer_equal;
            if (match_event) begin
                compare_latch <= next_latch;
            end
        end
    end

    // ****************************************
    // pins and trigger pulses
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_out    <= 1'b0;
            primary_oe_n   <= 1'b1;
            secondary_out  <= 1'b0;
            secondary_oe_n <= 1'b1;
            timer_reset    <= 1'b0;
            adc_start      <= 1'b0;
        end else begin
            primary_out    <= next_primary_out;
            primary_oe_n   <= next_primary_oe_n;         // (R6) (R10)
            secondary_out  <= pwm_secondary;
            secondary_oe_n <= next_second_oe_n;          // (R11)
            timer_reset    <= special_hit;               // (R7)
            adc_start      <= special_hit & adc_enabled; // (R7)
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    unmapped_error_a : assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !addr_mapped |=> pready && pslverr) // (R18)
        else $error("unmapped address not refused");
    bit_six_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
        !unit_mode_control[6])                          // (R18)
        else $error("control bit 6 stored");
    flag_on_capture_a : assert property (@(posedge pclk) disable iff (!presetn)
        capture_pulse |=> event_flag)                   // (R14)
        else $error("capture did not set flag");
    flag_sticky_a : assert property (@(posedge pclk) disable iff (!presetn)
        event_flag && !clear_flag |=> event_flag)       // (R14)
        else $error("flag dropped without clear");
    capture_value_a : assert property (@(posedge pclk) disable iff (!presetn)
        capture_pulse |=> stored_value == $past(first_timer_count)) // (R13)
        else $error("captured value wrong");
    off_clears_latch_a : assert property (@(posedge pclk)
        disable iff (!presetn)
        unit_off |=> !compare_latch)                    // (R2)
        else $error("latch kept while off");
    adc_start_cause_a : assert property (@(posedge pclk)
        disable iff (!presetn)
        adc_start |-> timer_reset && $past(adc_enabled)) // (R7)
        else $error("conversion start without cause");
    soft_pin_free_a : assert property (@(posedge pclk) disable iff (!presetn)
        mode_select_field == MODE_CMP_SOFT ##1
        mode_select_field == MODE_CMP_SOFT |-> primary_oe_n) // (R6)
        else $error("pin driven in flag-only mode");
    second_port_a : assert property (@(posedge pclk) disable iff (!presetn)
        !pwm_mode ##1 !pwm_mode |-> secondary_oe_n)     // (R10)
        else $error("secondary driven outside pwm");
    toggle_match_a : assert property (@(posedge pclk) disable iff (!presetn)
        match_event && mode_select_field == MODE_CMP_TOGGLE
        |=> compare_latch != $past(compare_latch))      // (R4)
        else $error("toggle missed");

    capture_seen_c : cover property (@(posedge pclk) disable iff (!presetn)
        capture_pulse);
    special_seen_c : cover property (@(posedge pclk) disable iff (!presetn)
        adc_start);
    set_clear_c : cover property (@(posedge pclk) disable iff (!presetn)
        set_flag && clear_flag);
    bridge_seen_c : cover property (@(posedge pclk) disable iff (!presetn)
        !secondary_oe_n && secondary_out);

endmodule

// ### hw/pwm_output_stage.sv
// duty comparison and output polarity for pwm modes
`timescale 1ns/1ps

module pwm_output_stage #(
    parameter int DUTY_WIDTH = 10
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  pwm_enable,     // pwm mode selected
    input  wire logic                  half_bridge,    // output_config_bit
    input  wire logic [1:0]            polarity,       // mode bits 1:0
    input  wire logic [DUTY_WIDTH-1:0] duty,
    input  wire logic [DUTY_WIDTH-1:0] timebase,       // second timer
    output logic                       primary_level,
    output logic                       secondary_level
);

    // ****************************************
    // parameter check
    // ****************************************
    if (DUTY_WIDTH < 3) begin : g_width_check
        $error("duty width too small");
    end

    // high while the second timer is below the duty value
    wire active = timebase < duty;                          // (R12)

    // registered levels; polarity bit 1 inverts the primary, bit 0 the secondary.
    // dead band is not timed here, the pair is complementary only for polarity 00 and 11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_level   <= 1'b0;
            secondary_level <= 1'b0;
        end else if (!pwm_enable) begin
            primary_level   <= 1'b0;
            secondary_level <= 1'b0;
        end else begin
            primary_level   <= active ^ polarity[1];        // (R8)
            secondary_level <= half_bridge &
                               (~active ^ polarity[0]);     // (R11)
        end
    end

endmodule

// ### testbench/event_pin_source.sv
// model of the external signal that drives the capture pin
`timescale 1ns/1ps

module event_pin_source (
    input  wire logic pclk, // core clock, edges follow it
    output logic      pin   // capture pin level at the pad
);
    // ****************************************
    // idle level
    // ****************************************
    // pin is an input to the unit, so the source alone sets it
    initial begin
        pin = 1'b0;
    end

    // ****************************************
    // pin edges
    // ****************************************
    // at least seven cycles per level: wider than the two-cycle minimum,
    // so the synchroniser never merges two edges
    task automatic level(input logic v);
        @(posedge pclk);
        pin <= v;
        repeat (6) @(posedge pclk);
    endtask

    // one high pulse, a single rising and falling edge
    task automatic pulse();
        level(1'b1);
        level(1'b0);
    endtask
endmodule

// ### testbench/test_enhanced_capture_compare_pwm_ctrl.sv
// self-checking bench for the capture/compare/pwm control block
`timescale 1ns/1ps

module test_enhanced_capture_compare_pwm_ctrl;
    import capture_compare_pkg::*;

    // ****************************************
    // signals and counters
    // ****************************************
    logic        pclk, presetn, psel, penable, pwrite, run, err;
    logic        pready, pslverr, primary_out, primary_oe_n, event_pin_in;
    logic        secondary_out, secondary_oe_n, timer_reset, adc_start;
    logic        adc_enabled, event_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] first_timer_count;
    logic [9:0]  second_timer_count;
    int          n_mismatch, n_checks, n_pulse;

    enhanced_capture_compare_pwm_ctrl uut (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .event_pin_in, .first_timer_count, .second_timer_count,
        .adc_enabled, .primary_out, .primary_oe_n, .secondary_out,
        .secondary_oe_n, .timer_reset, .adc_start, .event_flag);
    event_pin_source src (.pclk, .pin(event_pin_in));

    // core clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // first timer on the core clock; frozen for exact capture values
    always @(posedge pclk) begin
        if (timer_reset === 1'b1) first_timer_count <= 16'h0000;
        else if (run) first_timer_count <= first_timer_count + 16'h0001;
    end

    // counts timer reset and conversion start pulses
    always @(posedge pclk) begin
        n_pulse <= n_pulse + int'(timer_reset === 1'b1)
                   + int'(adc_start === 1'b1);
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic fail(input string s);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, s);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask

    // one apb transfer; ready and data taken at the same rising edge
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) fail("no ready");
        {psel, penable} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rdc(OFS_MODE_CONTROL, 32'h0);
        rdc(OFS_VALUE_LOW, 32'h0);
        wr(OFS_MODE_CONTROL, 32'hFF);
        rdc(OFS_MODE_CONTROL, 32'hBF);
        apb(8'h10, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(OFS_MODE_CONTROL, 32'h0);
        repeat (2) @(negedge pclk);
        chk({30'h0, primary_out, primary_oe_n}, 32'h1);
        $display("test regs done");
    endtask

    // falling then rising capture, overwrite and flag clearing
    task automatic t_capture();
        wr(OFS_MODE_CONTROL, 32'h04);
        wr(OFS_EVENT_STATUS, 32'h1);
        first_timer_count <= 16'hA5C3;
        src.level(1'b1);
        rdc(OFS_EVENT_STATUS, 32'h0);
        src.level(1'b0);
        rdc(OFS_VALUE_LOW, 32'hC3);
        rdc(OFS_VALUE_HIGH, 32'hA5);
        rdc(OFS_EVENT_STATUS, 32'h1);
        wr(OFS_MODE_CONTROL, 32'h05);
        first_timer_count <= 16'h3C5A;
        src.level(1'b1);
        rdc(OFS_VALUE_LOW, 32'h5A);
        rdc(OFS_VALUE_HIGH, 32'h3C);
        wr(OFS_EVENT_STATUS, 32'h1);
        rdc(OFS_EVENT_STATUS, 32'h0);
        src.level(1'b0);
        $display("test capture done");
    endtask

    // stale prescaler counts must vanish when the unit is turned off
    task automatic t_prescale(input logic [31:0] m, input int n);
        wr(OFS_MODE_CONTROL, m);
        repeat (2) src.pulse();
        wr(OFS_MODE_CONTROL, 32'h00);
        wr(OFS_MODE_CONTROL, m);
        wr(OFS_EVENT_STATUS, 32'h1);
        repeat (n - 1) src.pulse();
        rdc(OFS_EVENT_STATUS, 32'h0);
        src.pulse();
        rdc(OFS_EVENT_STATUS, 32'h1);
        $display("test prescale %0d done", n);
    endtask

    // compare with config bit set, which must be ignored here
    task automatic t_cmp(input logic [3:0] m, input logic po, input logic oe);
        int          t;
        int          p0;
        logic [15:0] tgt;
        wr(OFS_MODE_CONTROL, {24'h0, 4'h8, m});
        wr(OFS_EVENT_STATUS, 32'h1);
        tgt = first_timer_count + 16'h0040;
        wr(OFS_VALUE_LOW, {24'h0, tgt[7:0]});
        wr(OFS_VALUE_HIGH, {24'h0, tgt[15:8]});
        p0 = n_pulse;
        t = 0;
        run <= 1'b1;
        while (event_flag !== 1'b1 && t < 200) begin
            @(negedge pclk);
            t++;
        end
        repeat (3) @(posedge pclk);
        run <= 1'b0;
        @(negedge pclk);
        chk({31'h0, event_flag}, 32'h1);
        chk({30'h0, primary_out, primary_oe_n}, {30'h0, po, oe});
        chk(32'(n_pulse - p0), (m == 4'hB) ? 32'h2 : 32'h0);
        chk({31'h0, secondary_oe_n}, 32'h1);
        $display("test compare %h done", m);
    endtask

    // pwm just below and at the ten-bit duty value
    task automatic t_pwm(input logic [7:0] c);
        logic [9:0] duty;
        logic       act;
        duty = {8'h80, c[5:4]};
        wr(OFS_VALUE_LOW, 32'h80);
        wr(OFS_MODE_CONTROL, {24'h0, c});
        for (int i = 0; i < 2; i++) begin
            second_timer_count <= duty - 10'h001 + 10'(i);
            act = (i == 0);
            repeat (4) @(negedge pclk);
            chk({31'h0, primary_out}, {31'h0, act ^ c[1]});
            chk({31'h0, secondary_oe_n}, {31'h0, ~c[7]});
            if (c[7]) chk({31'h0, secondary_out}, {31'h0, ~act ^ c[0]});
            @(posedge pclk);
        end
        $display("test pwm %h done", c);
    endtask

    // ****************************************
    // verdict and main sequence
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {run, n_mismatch, n_checks, n_pulse} = '0;
        {adc_enabled, first_timer_count, second_timer_count} = 27'h4000000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_capture();
        t_prescale(32'h06, 4);
        t_prescale(32'h07, 16);
        t_cmp(4'h8, 1'b1, 1'b0);
        t_cmp(4'h9, 1'b0, 1'b0);
        t_cmp(4'h2, 1'b1, 1'b0);
        t_cmp(4'hA, 1'b1, 1'b1);
        t_cmp(4'hB, 1'b1, 1'b1);
        t_pwm(8'hBC);
        t_pwm(8'h0D);
        t_pwm(8'hAE);
        t_pwm(8'h9F);
        results();
    end

    // a hang ends the run through the same verdict
    initial begin
        #200000;
        fail("watchdog expired");
        results();
    end
endmodule
